// [led_blink_phase_output_control_bench.sv]
/* bench: controller and device on one link, driven over APB.
   assumes a 50 MHz clock and an asynchronous high reset */
`timescale 1ns/1ps
module led_blink_phase_output_control_bench
    import led_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic [NUM_OUT-1:0] pwmOnTime = '0;
    logic [NUM_OUT-1:0] pwmSel;
    logic pwmRun;
    int num_errors = 0;
    int compares = 0;
    int seed = 62;
    led_link_if link (.clk(clk));
    led_host_ctrl u_led_host_ctrl (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(), .link(link.host));
    led_phase_dev u_led_phase_dev (.clk(clk), .rst(rst), .pwmOnTime(pwmOnTime),
        .pwmSel(pwmSel), .pwmRun(pwmRun), .link(link.device));
    led_link_props u_props (.clk(clk), .rst(rst), .regReq(link.regReq),
        .regWe(link.regWe), .regAddr(link.regAddr), .regWData(link.regWData),
        .regAck(link.regAck), .regRData(link.regRData), .phasePin(link.phasePin),
        .ledOut(link.ledOut), .ledOe(link.ledOe));
    // 20 ns clock
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic complete_run();
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // look at pready between edges, away from the launching edge
        @(negedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        q = prdata;
        // the transfer completes at this edge; release only after it
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            complete_run();
        end
    endtask
    // one device register access through the controller
    task automatic dev(input logic wr, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q);
        logic [31:0] r;
        int n;
        apb(1'b1, APB_CMD, {15'h0, wr, d, a}, r);
        n = 0;
        do begin
            apb(1'b0, APB_STAT, 32'h0, r);
            n++;
        end while (r[STAT_BUSY] !== 1'b0 && n < 20);
        q = r[STAT_RDATA_LSB +: 8];
        if (n >= 20) begin
            num_errors++;
            complete_run();
        end
    endtask
    // reset values first, then random writes against the model
    initial begin
        logic [7:0] mdl [32];
        static logic [7:0] adr [11] = '{ADDR_PH0, ADDR_PH1, ADDR_MASTER, ADDR_CFG, ADDR_INT0,
            8'h11, 8'h12, ADDR_INT3, 8'h03, ADDR_MASTER, ADDR_CFG};
        logic [7:0] a, d, q, g;
        logic [8:0] lvl, ps;
        logic [3:0] nib;
        logic [31:0] r;
        logic pin, sel;
        int i, k;
        foreach (mdl[j]) mdl[j] = 8'h00;
        mdl[ADDR_PH0] = RST_PH;
        mdl[ADDR_PH1] = RST_PH;
        mdl[ADDR_MASTER] = RST_MASTER;
        mdl[ADDR_CFG] = RST_CFG;
        for (k = 16; k < 20; k++) mdl[k] = RST_INT;
        pin = 1'b0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 120; i++) begin
            a = adr[i % 11];
            if (i >= 11) begin
                a = adr[$unsigned($random(seed)) % 11];
                d = 8'($random(seed));
                pwmOnTime <= 9'($random(seed));
                pin = 1'($random(seed));
                apb(1'b1, APB_PIN, {31'h0, pin}, r);
                // one random register from the address list written with random data
                dev(1'b1, a, d, q);
                if (a != 8'h03) mdl[a] = (a == ADDR_CFG) ? (d & CFG_WMASK) : d;
            end
            dev(1'b0, a, 8'h00, q);
            check("reg", q, (a == ADDR_CFG) ? (mdl[a] | {1'b0, pin, 6'h0}) : mdl[a]);
            g = mdl[ADDR_CFG];
            sel = g[CFG_EN] & (g[CFG_FLIP] ^ pin);
            lvl = {sel ? g[CFG_O8P1] : g[CFG_O8P0], sel ? mdl[ADDR_PH1] : mdl[ADDR_PH0]};
            for (k = 0; k < NUM_OUT; k++) begin
                nib = 4'(mdl[ADDR_INT0 + k / 2] >> (4 * (k % 2)));
                if (k == 8 || g[CFG_GLOB]) nib = mdl[ADDR_MASTER][3:0];
                ps[k] = (mdl[ADDR_MASTER][7:4] != 4'h0) && (nib != NIB_STATIC);
            end
            check("pwmSel", pwmSel, ps);
            check("pwmRun", pwmRun, |ps);
            apb(1'b0, APB_LEDIN, 32'h0, r);
            check("ledIn", r, lvl ^ (ps & ~pwmOnTime));
        end
        complete_run();
    end
endmodule

// [led_host_ctrl.sv]
/*
 * Controller end: software orders register reads and writes over APB,
 * this module issues them on the link and reports status and pin levels.
 * Assumes the device answers every request with one regAck pulse.
 */
`timescale 1ns/1ps
module led_host_ctrl
    import led_pkg::*;
(
    input wire logic clk, // 50 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, never set
    led_link_if.host link // link to the device
);
    typedef struct packed {
        hostState_t state;
        logic req;
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic phase;
        logic [NUM_OUT-1:0] ledS1;
        logic [NUM_OUT-1:0] ledS2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } hostReg_t;

    hostReg_t q, d;
    logic wrEdge;

    // apb read decode, unmapped offsets read zero
    function automatic logic [31:0] apbRead(input hostReg_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            APB_CMD: begin
                r[7:0] = s.addr;
                r[CMD_WDATA_LSB +: 8] = s.wdata;
                r[CMD_WE] = s.we;
            end
            APB_STAT: begin
                r[STAT_BUSY] = (s.state == H_WAIT);
                r[STAT_RDATA_LSB +: 8] = s.rdata;
            end
            APB_PIN: r[PIN_PHASE] = s.phase;
            APB_LEDIN: r[NUM_OUT-1:0] = s.ledS2;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // next state: apb slave, link sequencer, pin synchroniser
    always_comb begin
        d = q;
        wrEdge = psel && penable && q.pready && pwrite;
        d.req = 1'b0;
        d.ledS1 = link.ledIn;
        d.ledS2 = q.ledS1;
        d.pready = psel && !penable;
        d.pslverr = 1'b0;
        if (psel && !penable) begin
            d.prdata = apbRead(q, paddr);
        end
        if (wrEdge && paddr == APB_PIN) begin
            d.phase = pwdata[PIN_PHASE];
        end
        case (q.state)
            H_IDLE: begin
                // a command write while busy is dropped
                if (wrEdge && paddr == APB_CMD) begin
                    d.addr = pwdata[7:0];
                    d.wdata = pwdata[CMD_WDATA_LSB +: 8];
                    d.we = pwdata[CMD_WE];
                    d.req = 1'b1;
                    d.state = H_WAIT;
                end
            end
            H_WAIT: begin
                if (link.regAck) begin
                    if (!q.we) begin
                        d.rdata = link.regRData;
                    end
                    d.state = H_IDLE;
                end
            end
            default: d.state = H_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '{state: H_IDLE, req: 1'b0, we: 1'b0, addr: 8'h00, wdata: 8'h00,
                   rdata: 8'h00, phase: 1'b0, ledS1: '0, ledS2: '0,
                   pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
        end else begin
            q <= d;
        end
    end

    // outputs from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign link.regReq = q.req;
    assign link.regWe = q.we;
    assign link.regAddr = q.addr;
    assign link.regWData = q.wdata;
    assign link.phasePin = q.phase;
endmodule

// [led_link_if.sv]
/*
 * Link between the LED driver device and its controller: a register
 * request/answer port, the external phase pin and nine open-drain outputs.
 * Assumes one clock shared by both ends; pull-ups are modelled here.
 */
`timescale 1ns/1ps
interface led_link_if (
    input wire logic clk // shared clock
);
    import led_pkg::*;

    logic regReq; // one-cycle register request
    logic regWe; // request is a write
    logic [7:0] regAddr; // register address
    logic [7:0] regWData; // write data
    logic regAck; // one-cycle answer
    logic [7:0] regRData; // read data, valid with regAck
    logic phasePin; // external phase input level
    logic [NUM_OUT-1:0] ledOut; // driven level, always low
    logic [NUM_OUT-1:0] ledOe; // high while pulling the output low
    logic [NUM_OUT-1:0] ledIn; // resolved pin level

    // open drain with pull-up: released pins read high
    assign ledIn = (ledOe & ledOut) | ~ledOe;

    modport device (
        input regReq, regWe, regAddr, regWData, phasePin, ledIn,
        output regAck, regRData, ledOut, ledOe
    );

    modport host (
        output regReq, regWe, regAddr, regWData, phasePin,
        input regAck, regRData, ledIn
    );
endinterface

// [led_link_props.sv]
/* link checker: shadows device registers from link writes.
   assumes the link signals of both ends at its inputs */
`timescale 1ns/1ps
module led_link_props
    import led_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic regReq, // request
    input wire logic regWe, // write
    input wire logic [7:0] regAddr, // address
    input wire logic [7:0] regWData, // write data
    input wire logic regAck, // answer
    input wire logic [7:0] regRData, // read data
    input wire logic phasePin, // phase pin
    input wire logic [NUM_OUT-1:0] ledOut, // drive level
    input wire logic [NUM_OUT-1:0] ledOe // pull enable
);
    logic [7:0] ph0Q, ph1Q, cfgQ, mstQ;
    wire rd = regReq && !regWe;
    wire sel = cfgQ[CFG_EN] & (cfgQ[CFG_FLIP] ^ phasePin);
    wire [8:0] wantOe = ~{sel ? cfgQ[CFG_O8P1] : cfgQ[CFG_O8P0], sel ? ph1Q : ph0Q};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // shadow of written registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph0Q <= RST_PH;
            ph1Q <= RST_PH;
            cfgQ <= RST_CFG;
            mstQ <= RST_MASTER;
        end else if (regReq && regWe) begin
            if (regAddr == ADDR_PH0) ph0Q <= regWData;
            if (regAddr == ADDR_PH1) ph1Q <= regWData;
            if (regAddr == ADDR_CFG) cfgQ <= regWData & CFG_WMASK;
            if (regAddr == ADDR_MASTER) mstQ <= regWData;
        end
    end
    property p_ack; regReq |=> regAck; endproperty
    a_ack: assert property (p_ack) else $error("request unanswered");
    property p_cause; regAck |-> $past(regReq); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_ph0; rd && regAddr == ADDR_PH0 |=> regRData == $past(ph0Q); endproperty
    a_ph0: assert property (p_ph0) else $error("phase zero readback");
    property p_ph1; rd && regAddr == ADDR_PH1 |=> regRData == $past(ph1Q); endproperty
    a_ph1: assert property (p_ph1) else $error("phase one readback");
    property p_cfg;
        $stable(phasePin)[*4] ##0 (rd && regAddr == ADDR_CFG)
        |=> regRData == ($past(cfgQ) | {1'b0, $past(phasePin), 6'h00});
    endproperty
    a_cfg: assert property (p_cfg) else $error("config readback");
    property p_off;
        !cfgQ[CFG_EN] && mstQ[7:4] == 4'h0 && $stable(mstQ) |=> ledOe == $past(wantOe);
    endproperty
    a_off: assert property (p_off) else $error("static level");
    property p_on;
        $stable(phasePin)[*4] ##0 (cfgQ[CFG_EN] && mstQ[7:4] == 4'h0 && $stable(mstQ))
        |=> ledOe == $past(wantOe);
    endproperty
    a_on: assert property (p_on) else $error("phase level");
    property p_drive; ledOut == 9'h000; endproperty
    a_drive: assert property (p_drive) else $error("output driven high");
    c_cfg: cover property (rd && regAddr == ADDR_CFG);
    c_blink: cover property (cfgQ[CFG_EN] && phasePin);
    c_pwm: cover property (mstQ[7:4] != 4'h0);
endmodule

// [led_phase_dev.sv]
/*
 * Device end: phase output registers, configuration, master and
 * individual intensity registers, output level and PWM selection.
 * Assumes an external timeslot generator supplies pwmOnTime on clk.
 */
// Decided for this implementation: the link register request/answer port.
`timescale 1ns/1ps
module led_phase_dev
    import led_pkg::*;
(
    input wire logic clk, // 50 MHz clock
    input wire logic rst, // async reset, active high
    input wire logic [NUM_OUT-1:0] pwmOnTime, // on-time from timeslot logic
    output logic [NUM_OUT-1:0] pwmSel, // outputs running PWM
    output logic pwmRun, // timeslot generator needed
    led_link_if.device link // link to the controller
);
    typedef struct packed {
        logic [7:0] ph0;
        logic [7:0] ph1;
        logic [7:0] master;
        logic [7:0] cfg;
        logic [3:0][7:0] inten;
        logic pinS1;
        logic pinS2;
        logic ack;
        logic [7:0] rdata;
        logic [NUM_OUT-1:0] oe;
        logic [NUM_OUT-1:0] pwmSel;
        logic pwmRun;
    } devReg_t;

    devReg_t q, d;

    // intensity nibble of one output
    function automatic logic [3:0] nibOf(input devReg_t s, input int i);
        logic [3:0] n;
        n = s.master[3:0];
        if (!s.cfg[CFG_GLOB] && i < NUM_OUT - 1) begin
            n = (i % 2 == 1) ? s.inten[i / 2][7:4] : s.inten[i / 2][3:0];
        end
        return n;
    endfunction

    // register read decode, unmapped addresses read zero
    function automatic logic [7:0] regRead(input devReg_t s, input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a >= ADDR_INT0 && a <= ADDR_INT3) begin
            r = s.inten[a[1:0]];
        end else begin
            case (a)
                ADDR_PH0: r = s.ph0;
                ADDR_PH1: r = s.ph1;
                ADDR_MASTER: r = s.master;
                ADDR_CFG: begin
                    r = s.cfg & CFG_WMASK;
                    r[CFG_PIN] = s.pinS2;
                end
                default: r = 8'h00;
            endcase
        end
        return r;
    endfunction

    logic phaseSel;
    logic pwmGlobal;
    logic [NUM_OUT-1:0] lvl;
    logic [NUM_OUT-1:0] pwmNext;
    logic [3:0] nib;

    // next state: register port, phase choice, output levels
    always_comb begin
        phaseSel = 1'b0;
        pwmGlobal = 1'b0;
        lvl = '0;
        pwmNext = '0;
        nib = 4'h0;
        d = q;
        d.pinS1 = link.phasePin;
        d.pinS2 = q.pinS1;
        d.ack = link.regReq;

        // writes; unmapped writes are dropped
        if (link.regReq && link.regWe) begin
            if (link.regAddr >= ADDR_INT0 && link.regAddr <= ADDR_INT3) begin
                d.inten[link.regAddr[1:0]] = link.regWData;
            end else begin
                case (link.regAddr)
                    ADDR_PH0: d.ph0 = link.regWData;
                    ADDR_PH1: d.ph1 = link.regWData;
                    ADDR_MASTER: d.master = link.regWData;
                    ADDR_CFG: d.cfg = link.regWData & CFG_WMASK;
                    default: d.cfg = q.cfg;
                endcase
            end
        end

        // reads answer in the cycle after the request
        if (link.regReq && !link.regWe) begin
            d.rdata = regRead(q, link.regAddr);
        end

        phaseSel = q.cfg[CFG_EN] & (q.cfg[CFG_FLIP] ^ q.pinS2);

        lvl[NUM_OUT-2:0] = phaseSel ? q.ph1 : q.ph0;

        lvl[NUM_OUT-1] = phaseSel ? q.cfg[CFG_O8P1] : q.cfg[CFG_O8P0];

        pwmGlobal = (q.master[7:4] != 4'h0);

        for (int i = 0; i < NUM_OUT; i++) begin
            nib = nibOf(q, i);
            pwmNext[i] = pwmGlobal && (nib != NIB_STATIC);
            // bit 1 releases, bit 0 pulls low
            if (pwmNext[i]) begin
                d.oe[i] = ~(lvl[i] ^ ~pwmOnTime[i]);
            end else begin
                d.oe[i] = ~lvl[i];
            end
        end
        d.pwmSel = pwmNext;
        d.pwmRun = |pwmNext;
    end

    // state register, reset to power-up contents
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '{ph0: RST_PH, ph1: RST_PH, master: RST_MASTER, cfg: RST_CFG,
                   inten: {4{RST_INT}}, pinS1: 1'b0, pinS2: 1'b0, ack: 1'b0,
                   rdata: 8'h00, oe: '0, pwmSel: '0, pwmRun: 1'b0};
        end else begin
            q <= d;
        end
    end

    // outputs from the state register; open drain drives only low
    assign link.regAck = q.ack;
    assign link.regRData = q.rdata;
    assign link.ledOe = q.oe;
    assign link.ledOut = '0;
    assign pwmSel = q.pwmSel;
    assign pwmRun = q.pwmRun;
endmodule

// [led_pkg.sv]
/*
 * Shared constants for the nine-output open-drain LED driver link:
 * device register map, field positions, reset values, host APB map.
 * Assumes both ends and the testbench import it whole.
 */
package led_pkg;
    // number of open-drain outputs, the ninth one included
    localparam int NUM_OUT = 9;

    // device register addresses
    localparam logic [7:0] ADDR_PH0 = 8'h01;
    localparam logic [7:0] ADDR_PH1 = 8'h09;
    localparam logic [7:0] ADDR_MASTER = 8'h0E;
    localparam logic [7:0] ADDR_CFG = 8'h0F;
    localparam logic [7:0] ADDR_INT0 = 8'h10;
    localparam logic [7:0] ADDR_INT3 = 8'h13;

    // device configuration field positions
    localparam int CFG_EN = 0;
    localparam int CFG_FLIP = 1;
    localparam int CFG_GLOB = 2;
    localparam int CFG_O8P0 = 4;
    localparam int CFG_O8P1 = 5;
    localparam int CFG_PIN = 6;
    localparam logic [7:0] CFG_WMASK = 8'h37;

    // device reset values
    localparam logic [7:0] RST_PH = 8'hFF;
    localparam logic [7:0] RST_MASTER = 8'h0F;
    localparam logic [7:0] RST_CFG = 8'h34;
    localparam logic [7:0] RST_INT = 8'hFF;

    // intensity nibble meaning a static output
    localparam logic [3:0] NIB_STATIC = 4'hF;

    // host APB register byte offsets
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_STAT = 8'h04;
    localparam logic [7:0] APB_PIN = 8'h08;
    localparam logic [7:0] APB_LEDIN = 8'h0C;

    // host APB field positions
    localparam int CMD_WDATA_LSB = 8;
    localparam int CMD_WE = 16;
    localparam int STAT_BUSY = 0;
    localparam int STAT_RDATA_LSB = 8;
    localparam int PIN_PHASE = 0;

    // host sequencer states
    typedef enum logic [0:0] {
        H_IDLE = 1'b0,
        H_WAIT = 1'b1
    } hostState_t;
endpackage
